// [src/afcdt_defs.svh]
`ifndef AFCDT_DEFS_SVH
`define AFCDT_DEFS_SVH

// channel order: 0 first remote, 1 local, 2 second remote
`define AFCDT_NUM_CHAN        3
`define AFCDT_NUM_PWM         3
`define AFCDT_NUM_TACH        4

`define AFCDT_OFS_R1_TARGET   8'h33
`define AFCDT_OFS_LOC_TARGET  8'h34
`define AFCDT_OFS_R2_TARGET   8'h35
`define AFCDT_TARGET_RESET    8'hA4

`define AFCDT_FANSEL_REMOTE1  3'h0
`define AFCDT_FANSEL_LOCAL    3'h1
`define AFCDT_FANSEL_REMOTE2  3'h2
`define AFCDT_FANSEL_FULL     3'h3
`define AFCDT_FANSEL_OFF      3'h4
`define AFCDT_FANSEL_MAX_LR2  3'h5
`define AFCDT_FANSEL_MAX_ALL  3'h6
`define AFCDT_FANSEL_MANUAL   3'h7

`define AFCDT_DUTY_FULL       8'hFF
`define AFCDT_DUTY_OFF        8'h00
`define AFCDT_DYN_STEP        8'h01
`define AFCDT_DYN_HYST        8'h04
`define AFCDT_TEMP_MAX        8'hFF
`define AFCDT_TACH_MAX        8'hFF

`endif

// [src/afcdt_fan_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "afcdt_defs.svh"

// Function
// R01 - regulates fans alone once programmed
// R02 - three pwm outputs, four tach monitors
// R03 - independent calibration per temperature channel
// R04 - per output min duty, fail threshold, ramp
// R05 - fan on above fan-on temperature
// R06 - span sets duty slope above fan-on
// R07 - below low limit sets status flag
// R08 - above high limit sets status flag
// R09 - above critical limit forces full duty
// R10 - dynamic mode steers fan-on toward target
// R11 - one target register per channel
// R12 - targets reset to 100 degrees code
// R13 - software programs basics before dynamic mode
// R14 - core rail low suspends dynamic adjustment
// R15 - behaviour field selects controlling channel
// R16 - duty rises linearly min to full
// R17 - fixed dynamic steps once per measurement
module afcdt_fan_ctrl (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic [7:0]                reg_addr,
    input  wire logic                      reg_wr,
    input  wire afcdt_pkg::afcdt_temp_type reg_wdata,
    output var  afcdt_pkg::afcdt_temp_type reg_rdata,
    input  wire logic                      meas_done,
    input  wire afcdt_pkg::afcdt_temp_type temp              [3],
    input  wire afcdt_pkg::afcdt_temp_type fan_on_temp       [3],
    input  wire afcdt_pkg::afcdt_span_type duty_slope_span   [3],
    input  wire afcdt_pkg::afcdt_temp_type low_temp_limit    [3],
    input  wire afcdt_pkg::afcdt_temp_type high_temp_limit   [3],
    input  wire afcdt_pkg::afcdt_temp_type critical_temp_limit [3],
    input  wire logic [2:0]                critical_enable,
    input  wire logic [2:0]                dynamic_enable,
    input  wire logic [2:0]                alert_enable,
    input  wire logic                      status_clear,
    input  wire logic                      cpu_core_rail_low,
    input  wire afcdt_pkg::afcdt_fansel_type fan_behaviour_select [3],
    input  wire afcdt_pkg::afcdt_duty_type min_fan_duty      [3],
    input  wire afcdt_pkg::afcdt_duty_type manual_duty       [3],
    input  wire afcdt_pkg::afcdt_duty_type ramp_step         [3],
    input  wire logic [7:0]                tach_fail_limit   [3],
    input  wire logic [3:0]                tach_in,
    output var  afcdt_pkg::afcdt_temp_type active_fan_on_temp [3],
    output var  afcdt_pkg::afcdt_duty_type duty_now          [3],
    output var  logic [2:0]                pwm_out,
    output var  logic [7:0]                tach_count        [4],
    output var  logic [3:0]                fan_fail,
    output var  logic [2:0]                low_flag,
    output var  logic [2:0]                high_flag,
    output logic                           alert
);
    import afcdt_pkg::*;

    afcdt_temp_type target [3];
    afcdt_temp_type fot_q  [3];
    afcdt_temp_type fot_d  [3];
    afcdt_duty_type duty_q [3];
    afcdt_duty_type duty_d [3];
    afcdt_duty_type goal   [3];
    afcdt_duty_type ch_duty [3][3];
    logic [7:0]     pcnt_q;
    logic [7:0]     pcnt_d;
    logic [2:0]     pwm_q;
    logic [2:0]     pwm_d;
    logic [2:0]     low_q;
    logic [2:0]     low_d;
    logic [2:0]     high_q;
    logic [2:0]     high_d;
    logic [3:0]     tsync1_q;
    logic [3:0]     tsync2_q;
    logic [3:0]     tsync3_q;
    logic           rail1_q;
    logic           rail2_q;
    logic [7:0]     tacc_q [4];
    logic [7:0]     tacc_d [4];
    logic [7:0]     tcnt_q [4];
    logic [7:0]     tcnt_d [4];
    logic [3:0]     fail_q;
    logic [3:0]     fail_d;

    afcdt_target_regs u_targets ( // [R11] [R12]
        .clock     (clock),
        .rst       (rst),
        .reg_addr  (reg_addr),
        .reg_wr    (reg_wr),
        .reg_wdata (reg_wdata),
        .reg_rdata (reg_rdata),
        .target    (target)
    );

    // duty for one channel seen through one output's minimum duty
    function automatic afcdt_duty_type calc_duty(
        input afcdt_temp_type t,
        input afcdt_temp_type fot,
        input afcdt_span_type span,
        input afcdt_duty_type mind,
        input afcdt_temp_type crit,
        input logic           crit_en
    );
        logic [7:0]  diff;
        logic [7:0]  room;
        logic [15:0] scaled;
        diff   = t - fot;
        room   = `AFCDT_DUTY_FULL - mind;
        scaled = (16'(room) * 16'(diff)) >> span;
        if (crit_en && t > crit) begin
            calc_duty = `AFCDT_DUTY_FULL; // [R09]
        end else if (t <= fot) begin
            calc_duty = `AFCDT_DUTY_OFF; // [R05]
        end else if (scaled >= 16'(room)) begin
            calc_duty = `AFCDT_DUTY_FULL; // [R06]
        end else begin
            calc_duty = mind + scaled[7:0]; // [R16]
        end
    endfunction

    function automatic afcdt_duty_type max2(input afcdt_duty_type a, input afcdt_duty_type b);
        max2 = (a > b) ? a : b;
    endfunction

    // dynamic fan-on temperature, one step per measurement
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            fot_d[c] = fot_q[c];
            if (!dynamic_enable[c]) begin
                fot_d[c] = fan_on_temp[c]; // [R03]
            end else if (meas_done && !rail2_q) begin // [R14]
                if (temp[c] > target[c] && fot_q[c] >= `AFCDT_DYN_STEP) begin
                    fot_d[c] = fot_q[c] - `AFCDT_DYN_STEP; // [R10] [R17]
                end else if (temp[c] < target[c] - `AFCDT_DYN_HYST
                             && target[c] >= `AFCDT_DYN_HYST
                             && fot_q[c] <= `AFCDT_TEMP_MAX - `AFCDT_DYN_STEP) begin
                    fot_d[c] = fot_q[c] + `AFCDT_DYN_STEP; // [R17]
                end
            end
        end
    end

    // channel duties, behaviour mux and ramp
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            for (int c = 0; c < 3; c++) begin
                ch_duty[p][c] = calc_duty(temp[c], fot_q[c], duty_slope_span[c],
                                          min_fan_duty[p], critical_temp_limit[c],
                                          critical_enable[c]);
            end
            unique case (fan_behaviour_select[p]) // [R15]
                `AFCDT_FANSEL_REMOTE1: goal[p] = ch_duty[p][0];
                `AFCDT_FANSEL_LOCAL:   goal[p] = ch_duty[p][1];
                `AFCDT_FANSEL_REMOTE2: goal[p] = ch_duty[p][2];
                `AFCDT_FANSEL_FULL:    goal[p] = `AFCDT_DUTY_FULL;
                `AFCDT_FANSEL_OFF:     goal[p] = `AFCDT_DUTY_OFF;
                `AFCDT_FANSEL_MAX_LR2: goal[p] = max2(ch_duty[p][1], ch_duty[p][2]);
                `AFCDT_FANSEL_MAX_ALL: goal[p] = max2(ch_duty[p][0],
                                                      max2(ch_duty[p][1], ch_duty[p][2]));
                `AFCDT_FANSEL_MANUAL:  goal[p] = manual_duty[p];
            endcase
            duty_d[p] = duty_q[p];
            if (meas_done) begin // [R01]
                if (ramp_step[p] == 8'h00) begin
                    duty_d[p] = goal[p];
                end else if (goal[p] > duty_q[p]) begin
                    duty_d[p] = (goal[p] - duty_q[p] > ramp_step[p])
                              ? duty_q[p] + ramp_step[p] : goal[p]; // [R04]
                end else begin
                    duty_d[p] = (duty_q[p] - goal[p] > ramp_step[p])
                              ? duty_q[p] - ramp_step[p] : goal[p]; // [R04]
                end
            end
        end
    end

    // pwm waveform, full code gives a steady high
    always_comb begin
        pcnt_d = pcnt_q + 8'h01;
        for (int p = 0; p < 3; p++) begin
            pwm_d[p] = (duty_q[p] == `AFCDT_DUTY_FULL) || (pcnt_q < duty_q[p]); // [R02]
        end
    end

    // sticky limit flags, set wins over clear
    always_comb begin
        low_d  = status_clear ? 3'h0 : low_q;
        high_d = status_clear ? 3'h0 : high_q;
        for (int c = 0; c < 3; c++) begin
            if (meas_done && temp[c] < low_temp_limit[c]) begin
                low_d[c] = 1'b1; // [R07]
            end
            if (meas_done && temp[c] > high_temp_limit[c]) begin
                high_d[c] = 1'b1; // [R08]
            end
        end
    end

    // tach edge counting per measurement cycle
    always_comb begin
        for (int f = 0; f < 4; f++) begin
            tacc_d[f] = tacc_q[f];
            tcnt_d[f] = tcnt_q[f];
            fail_d[f] = fail_q[f];
            if (tsync2_q[f] && !tsync3_q[f] && tacc_q[f] != `AFCDT_TACH_MAX) begin
                tacc_d[f] = tacc_q[f] + 8'h01;
            end
            if (meas_done) begin
                tcnt_d[f] = tacc_q[f]; // [R02]
                tacc_d[f] = 8'h00;
                fail_d[f] = tacc_q[f] < tach_fail_limit[(f > 2) ? 2 : f]; // [R04]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                fot_q[i]  <= 8'h00;
                duty_q[i] <= 8'h00;
            end
            for (int f = 0; f < 4; f++) begin
                tacc_q[f] <= 8'h00;
                tcnt_q[f] <= 8'h00;
            end
            pcnt_q   <= 8'h00;
            pwm_q    <= 3'h0;
            low_q    <= 3'h0;
            high_q   <= 3'h0;
            fail_q   <= 4'h0;
            tsync1_q <= 4'h0;
            tsync2_q <= 4'h0;
            tsync3_q <= 4'h0;
            rail1_q  <= 1'b0;
            rail2_q  <= 1'b0;
        end else begin
            fot_q    <= fot_d;
            duty_q   <= duty_d;
            tacc_q   <= tacc_d;
            tcnt_q   <= tcnt_d;
            pcnt_q   <= pcnt_d;
            pwm_q    <= pwm_d;
            low_q    <= low_d;
            high_q   <= high_d;
            fail_q   <= fail_d;
            tsync1_q <= tach_in;
            tsync2_q <= tsync1_q;
            tsync3_q <= tsync2_q;
            rail1_q  <= cpu_core_rail_low;
            rail2_q  <= rail1_q;
        end
    end

    assign active_fan_on_temp = fot_q;
    assign duty_now           = duty_q;
    assign pwm_out            = pwm_q;
    assign tach_count         = tcnt_q;
    assign fan_fail           = fail_q;
    assign low_flag           = low_q;
    assign high_flag          = high_q;
    assign alert              = |((low_q | high_q) & alert_enable); // [R07] [R08]

    a_dyn_suspend_hold: assert property (@(posedge clock) disable iff (rst) // [R14]
        dynamic_enable[0] && rail2_q ##1 dynamic_enable[0] |-> $stable(fot_q[0]))
        else $error("fan-on temperature moved while core rail low");

    a_dyn_step_down: assert property (@(posedge clock) disable iff (rst) // [R10]
        dynamic_enable[0] && !rail2_q && meas_done && temp[0] > target[0]
        && fot_q[0] != 8'h00 |=> fot_q[0] == $past(fot_q[0]) - 8'h01)
        else $error("fan-on temperature did not step down");

    a_fan_off_below: assert property (@(posedge clock) disable iff (rst) // [R05]
        meas_done && fan_behaviour_select[0] == 3'h0 && ramp_step[0] == 8'h00
        && !critical_enable[0] && temp[0] <= fot_q[0] |=> duty_q[0] == 8'h00)
        else $error("fan not off at or below fan-on temperature");

    a_crit_full_duty: assert property (@(posedge clock) disable iff (rst) // [R09]
        meas_done && fan_behaviour_select[0] == 3'h0 && ramp_step[0] == 8'h00
        && critical_enable[0] && temp[0] > critical_temp_limit[0]
        |=> duty_q[0] == 8'hFF ##1 pwm_q[0])
        else $error("critical temperature did not force full duty");

    a_low_flag_set: assert property (@(posedge clock) disable iff (rst) // [R07]
        meas_done && temp[0] < low_temp_limit[0] |=> low_q[0])
        else $error("low limit flag not set");

    a_high_flag_set: assert property (@(posedge clock) disable iff (rst) // [R08]
        meas_done && temp[0] > high_temp_limit[0] |=> high_q[0])
        else $error("high limit flag not set");

    a_ramp_bounded: assert property (@(posedge clock) disable iff (rst) // [R04]
        meas_done && ramp_step[1] != 8'h00 && goal[1] > duty_q[1]
        |=> duty_q[1] > $past(duty_q[1])
            && duty_q[1] - $past(duty_q[1]) <= $past(ramp_step[1]))
        else $error("ramp exceeded its step");

    a_full_speed_mode: assert property (@(posedge clock) disable iff (rst) // [R15]
        meas_done && fan_behaviour_select[2] == 3'h3 && ramp_step[2] == 8'h00
        |=> duty_q[2] == 8'hFF)
        else $error("full speed behaviour not at full duty");

endmodule

`default_nettype wire

// [src/afcdt_pkg.sv]
package afcdt_pkg;
    typedef logic [7:0] afcdt_temp_type;
    typedef logic [7:0] afcdt_duty_type;
    typedef logic [2:0] afcdt_fansel_type;
    typedef logic [2:0] afcdt_span_type;
endpackage

// [src/afcdt_target_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "afcdt_defs.svh"

module afcdt_target_regs (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic [7:0]               reg_addr,
    input  wire logic                     reg_wr,
    input  wire afcdt_pkg::afcdt_temp_type reg_wdata,
    output var  afcdt_pkg::afcdt_temp_type reg_rdata,
    output var  afcdt_pkg::afcdt_temp_type target [3]
);
    import afcdt_pkg::*;

    afcdt_temp_type tgt_q [3];
    afcdt_temp_type tgt_d [3];
    afcdt_temp_type rdata_q;
    afcdt_temp_type rdata_d;

    function automatic logic [1:0] addr_index(input logic [7:0] a);
        unique case (a)
            `AFCDT_OFS_R1_TARGET:  addr_index = 2'd0;
            `AFCDT_OFS_LOC_TARGET: addr_index = 2'd1;
            `AFCDT_OFS_R2_TARGET:  addr_index = 2'd2;
            default:               addr_index = 2'd3;
        endcase
    endfunction

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            tgt_d[i] = tgt_q[i];
        end
        if (reg_wr && addr_index(reg_addr) != 2'd3) begin
            tgt_d[addr_index(reg_addr)] = reg_wdata; // [R11]
        end
        rdata_d = (addr_index(reg_addr) == 2'd3) ? 8'h00 : tgt_q[addr_index(reg_addr)];
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                tgt_q[i] <= `AFCDT_TARGET_RESET; // [R12]
            end
            rdata_q <= 8'h00;
        end else begin
            tgt_q   <= tgt_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign target    = tgt_q;

    a_target_reset_val: assert property (@(posedge clock) disable iff (rst) // [R12]
        $fell(rst) |-> (tgt_q[0] == 8'hA4 && tgt_q[1] == 8'hA4 && tgt_q[2] == 8'hA4))
        else $error("target not at reset value after reset");

endmodule

`default_nettype wire

// [tb/afcdt_fan_model.sv]
`timescale 1ns/1ps
`default_nettype none
module afcdt_fan_model #(
    parameter int HALF = 4
) (
    input  wire logic       clock,
    input  wire logic [2:0] pwm_out,
    output var  logic [3:0] tach_in
);
    int spin [4];
    int ph   [4];
    logic [3:0] tach_q = 4'h0;
    assign tach_in = tach_q;
    // fan coasts a short while after drive stops; tach line stands still when stopped
    always @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            if (pwm_out[(i > 2) ? 2 : i]) spin[i] = 64;
            else if (spin[i] > 0) spin[i] = spin[i] - 1;
            if (spin[i] > 0) begin
                ph[i] = ph[i] + 1;
                if (ph[i] >= HALF) begin
                    ph[i] = 0;
                    tach_q[i] <= ~tach_q[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// [tb/auto_fan_control_dynamic_fan_on_temp_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "afcdt_defs.svh"
module auto_fan_control_dynamic_fan_on_temp_tb_top;
    import afcdt_pkg::*;
    logic clock = 0, rst = 1, reg_wr = 0, meas_done = 0, status_clear = 0, rail_low = 0;
    logic [7:0] reg_addr = 8'h00;
    afcdt_temp_type reg_wdata = 8'h00, reg_rdata;
    afcdt_temp_type temp [3], fot [3], lo [3], hi [3], crit [3], act [3];
    afcdt_span_type span [3];
    afcdt_fansel_type fsel [3];
    afcdt_duty_type mind [3], man [3], ramp [3], duty [3];
    logic [7:0] fail_lim [3], tcount [4];
    logic [2:0] crit_en = 0, dyn_en = 0, al_en = 0, pwm, lowf, highf;
    logic [3:0] tach, fan_fail;
    logic alert;
    int errors = 0, checks = 0;
    always #12.5 clock = ~clock;
    afcdt_fan_ctrl dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .meas_done(meas_done), .temp(temp),
        .fan_on_temp(fot), .duty_slope_span(span), .low_temp_limit(lo), .high_temp_limit(hi),
        .critical_temp_limit(crit), .critical_enable(crit_en), .dynamic_enable(dyn_en),
        .alert_enable(al_en), .status_clear(status_clear), .cpu_core_rail_low(rail_low),
        .fan_behaviour_select(fsel), .min_fan_duty(mind), .manual_duty(man),
        .ramp_step(ramp), .tach_fail_limit(fail_lim), .tach_in(tach),
        .active_fan_on_temp(act), .duty_now(duty), .pwm_out(pwm), .tach_count(tcount),
        .fan_fail(fan_fail), .low_flag(lowf), .high_flag(highf), .alert(alert));
    afcdt_fan_model #(.HALF(4)) fan_u (.clock(clock), .pwm_out(pwm), .tach_in(tach));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock) begin
            reg_wr = 1;
            reg_addr = a;
            reg_wdata = d;
        end
        @(negedge clock) reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock) reg_addr = a;
        @(negedge clock) chk(reg_rdata, exp);
    endtask
    task automatic meas();
        @(negedge clock) meas_done = 1;
        @(negedge clock) meas_done = 0;
        repeat (3) @(negedge clock);
    endtask
    task automatic test_regs();
        rd(`AFCDT_OFS_R1_TARGET, 8'ha4);
        rd(`AFCDT_OFS_LOC_TARGET, 8'ha4);
        rd(`AFCDT_OFS_R2_TARGET, 8'ha4);
        wr(`AFCDT_OFS_R1_TARGET, 8'h40);
        wr(`AFCDT_OFS_LOC_TARGET, 8'h51);
        wr(`AFCDT_OFS_R2_TARGET, 8'h62);
        wr(8'h36, 8'h99);
        rd(`AFCDT_OFS_R1_TARGET, 8'h40);
        rd(`AFCDT_OFS_LOC_TARGET, 8'h51);
        rd(`AFCDT_OFS_R2_TARGET, 8'h62);
        rd(8'h36, 8'h00);
        $display("test regs done");
    endtask
    task automatic test_modes();
        logic [7:0] exp [8];
        exp = '{8'hff, 8'h00, 8'h9f, 8'hff, 8'h00, 8'h9f, 8'hff, 8'h77};
        @(negedge clock) begin
            temp[0] = 8'h58;
            temp[1] = 8'h50;
            temp[2] = 8'h54;
        end
        for (int c = 0; c < 8; c++) begin
            @(negedge clock) fsel[0] = 3'(c);
            meas();
            chk(duty[0], exp[c]);
        end
        $display("test modes done");
    endtask
    task automatic test_crit_flags();
        @(negedge clock) begin
            fsel[0] = `AFCDT_FANSEL_REMOTE1;
            fot[0] = 8'hb0;
            crit_en = 3'h1;
            al_en = 3'h0;
            temp[0] = 8'hd8;
            temp[1] = 8'h30;
            temp[2] = 8'h30;
        end
        meas();
        chk(duty[0], 8'hff);
        chk({7'h0, pwm[0]}, 8'h01);
        chk({5'h0, highf}, 8'h01);
        chk({7'h0, alert}, 8'h00);
        @(negedge clock) al_en = 3'h1;
        @(negedge clock) chk({7'h0, alert}, 8'h01);
        @(negedge clock) begin
            status_clear = 1;
            temp[0] = 8'h10;
            crit_en = 3'h0;
        end
        @(negedge clock) status_clear = 0;
        @(negedge clock) chk({5'h0, highf}, 8'h00);
        meas();
        chk({5'h0, lowf}, 8'h01);
        chk({7'h0, alert}, 8'h01);
        chk(duty[0], 8'h00);
        $display("test crit flags done");
    endtask
    task automatic test_dynamic();
        @(negedge clock) begin fot[0] = 8'h50; temp[0] = 8'h60; end
        repeat (2) @(negedge clock);
        chk(act[0], 8'h50);
        @(negedge clock) dyn_en = 3'h1;
        meas();
        chk(act[0], 8'h4f);
        @(negedge clock) rail_low = 1;
        repeat (4) @(negedge clock);
        meas();
        chk(act[0], 8'h4f);
        @(negedge clock) rail_low = 0;
        repeat (4) @(negedge clock);
        meas();
        chk(act[0], 8'h4e);
        @(negedge clock) temp[0] = 8'h30;
        meas();
        chk(act[0], 8'h4f);
        chk(act[1], 8'h50);
        @(negedge clock) dyn_en = 3'h0;
        $display("test dynamic done");
    endtask
    task automatic test_tach();
        @(negedge clock) begin
            for (int i = 0; i < 3; i++) fsel[i] = `AFCDT_FANSEL_FULL;
            fail_lim[2] = 8'hc8;
        end
        meas();
        repeat (20) @(negedge clock);
        meas();
        // 201 clocks between captures: 200 edges of detection, one tach rise per 8
        repeat (196) @(negedge clock);
        meas();
        chk({4'h0, fan_fail}, 8'h0c);
        chk({5'h0, pwm}, 8'h07);
        for (int i = 0; i < 4; i++) chk(tcount[i], 8'h19);
        $display("test tach done");
    endtask
    task automatic test_ramp();
        logic [7:0] exp [6];
        exp = '{8'hcf, 8'h9f, 8'h77, 8'ha7, 8'hd7, 8'he0};
        @(negedge clock) begin
            fsel[1] = `AFCDT_FANSEL_MANUAL;
            ramp[1] = 8'h30;
        end
        for (int i = 0; i < 6; i++) begin
            if (i == 3) @(negedge clock) man[1] = 8'he0;
            meas();
            chk(duty[1], exp[i]);
        end
        $display("test ramp done");
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200_000;
        errors++;
        stop_test();
    end
    initial begin
        for (int i = 0; i < 3; i++) begin
            temp[i] = 8'h30;
            fot[i] = 8'h50;
            lo[i] = 8'h20;
            hi[i] = 8'hc0;
            crit[i] = 8'hd0;
            span[i] = 3'h3;
            fsel[i] = `AFCDT_FANSEL_OFF;
            mind[i] = 8'h40;
            man[i] = 8'h77;
            ramp[i] = 8'h00;
            fail_lim[i] = 8'h05;
        end
        repeat (2) @(negedge clock);
        rst = 0;
        test_regs();
        test_modes();
        test_crit_flags();
        test_dynamic();
        test_tach();
        test_ramp();
        stop_test();
    end
endmodule
`default_nettype wire
